// file: core/tmr_pkg.sv
package tmr_pkg;

  // =====================================================
  // register byte offsets (APB, one aligned word each)
  localparam logic [7:0] OFS_CFG0 = 8'h00; // config_reg_zero
  localparam logic [7:0] OFS_CFG1 = 8'h04; // config_reg_one
  localparam logic [7:0] OFS_CFG2 = 8'h08; // config_reg_two
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_COMPARE = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14; // count_register, 16-bit view
  localparam logic [7:0] OFS_COUNT_LOW = 8'h18; // count_low_byte, 8-bit view
  localparam logic [7:0] OFS_CAPTURE = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // =====================================================
  // config_reg_zero fields
  localparam int CFG0_RUN_BIT = 0;
  localparam int CFG0_MODE_BIT = 1;
  localparam int CFG0_DB_BIT = 2;

  // config_reg_two fields
  localparam int CFG2_GATE_LSB = 0;
  localparam int CFG2_CMP_LSB = 2;

  // status: sticky occurrence bits [3:0], mask bits [11:8]
  localparam int ST_TC = 0;
  localparam int ST_CMP = 1;
  localparam int ST_CAP = 2;
  localparam int ST_STOP = 3;
  localparam int ST_MASK_LSB = 8;

  // =====================================================
  // reset values and the stop-on-interrupt gate encoding
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [1:0] GATE_STOP_ON_IRQ = 2'h3;

  // compare type encodings
  typedef enum logic [2:0] {
    CMP_EQ = 3'h0,
    CMP_LT = 3'h1,
    CMP_LE = 3'h2,
    CMP_GT = 3'h3,
    CMP_GE = 3'h4
  } cmp_type_t;

  // pin outputs travel together
  typedef struct packed {
    logic cmp;
    logic tc;
  } pin_out_t;

endpackage

// file: core/tmr_compare.sv
`timescale 1ns/1ps
// =====================================================
// compare condition decode and output shaping
module tmr_compare (
  input wire logic mclk_i, // block clock
  input wire logic reset_i, // sync reset, active high
  input wire logic pwm_i, // comparator mode active
  input wire logic run_i, // count advancing this cycle
  input wire logic reload_i, // count reloads from period next edge
  input wire logic [2:0] type_i, // compare type
  input wire logic [15:0] count_i, // present count
  input wire logic [15:0] compare_i, // compare value
  output logic cmp_o, // compare output level
  output logic event_o // compare interrupt event, one cycle except less-than, which holds while count is below compare
);

  // raw relation of count against compare value
  function automatic logic cond(input logic [2:0] t, input logic [15:0] c,
                                input logic [15:0] v);
    case (t)
      tmr_pkg::CMP_EQ: cond = (c == v);
      tmr_pkg::CMP_LT: cond = (c < v);
      tmr_pkg::CMP_LE: cond = (c <= v);
      tmr_pkg::CMP_GT: cond = (c > v);
      tmr_pkg::CMP_GE: cond = (c >= v);
      default: cond = 1'b0;
    endcase
  endfunction

  logic cmp_r;
  logic ev_r;
  logic live;

  assign live = cond(type_i, count_i, compare_i);

  // output only follows the condition while counting, so a stopped
  // timer freezes a high level instead of dropping it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cmp_r <= 1'b0;
    end else if (!pwm_i) begin
      cmp_r <= 1'b0;
    end else if (run_i) begin
      cmp_r <= live;
    end
  end

  // interrupt event: equality types fire on match, less-than while below,
  // greater types once just after the reload
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ev_r <= 1'b0;
    end else begin
      case (type_i)
        tmr_pkg::CMP_EQ, tmr_pkg::CMP_LE: ev_r <= pwm_i && run_i && count_i == compare_i;
        tmr_pkg::CMP_LT: ev_r <= pwm_i && run_i && live;
        tmr_pkg::CMP_GT, tmr_pkg::CMP_GE: ev_r <= pwm_i && reload_i && run_i;
        default: ev_r <= 1'b0;
      endcase
    end
  end

  assign cmp_o = cmp_r;
  assign event_o = ev_r;

endmodule // tmr_compare

// file: core/tmr_apb_regs.sv
`timescale 1ns/1ps
// =====================================================
// APB slave decode helper: zero wait state, error on unmapped
module tmr_apb_decode (
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic [7:0] paddr_i, // apb byte address
  output logic access_o, // access phase
  output logic mapped_o, // address hits a register
  output logic pready_o, // apb ready
  output logic pslverr_o // apb error
);

  // word-aligned hit test for every register offset
  always_comb begin
    case (paddr_i)
      tmr_pkg::OFS_CFG0, tmr_pkg::OFS_CFG1, tmr_pkg::OFS_CFG2,
      tmr_pkg::OFS_PERIOD, tmr_pkg::OFS_COMPARE, tmr_pkg::OFS_COUNT,
      tmr_pkg::OFS_COUNT_LOW, tmr_pkg::OFS_CAPTURE, tmr_pkg::OFS_STATUS: mapped_o = 1'b1;
      default: mapped_o = 1'b0;
    endcase
  end

  assign access_o = psel_i & penable_i;
  assign pready_o = access_o; // no wait states, answer in first access cycle
  assign pslverr_o = access_o & ~mapped_o;

endmodule // tmr_apb_decode

// file: core/tmr_block.sv
`timescale 1ns/1ps
// Behaviour
// - stop-on-interrupt mode counts after run bit set, stops on block interrupt
// - terminal count or capture events stop it; stop events do not, and compare events only occur in comparator mode
// - hardware clears run bit on stop; software must set it again
// - 16-bit count read outside comparator mode returns full count and copies it to capture
// - low byte read outside comparator mode captures both count bytes into capture register
// - comparator period is period value plus one, times one block clock
// - mode bit one selects comparator; type from config_reg_two three bits
// - type 000 eq, 001 lt, 010 le, 011 gt, 100 ge
// - true compare asserts output or interrupt, counting goes on
// - comparator reloads period at terminal count and keeps comparing
// - compare interrupt only raised when its mask bit is set
// - comparator mode with dead band bit drives terminal pin as complement
// - count register reads zero in comparator mode
// - type 000 gives one-cycle pulse and interrupt at equality
// - type 001 high below compare until terminal count
// - type 010 high from equality until terminal count
// - type 011 high from reload until count reaches compare plus one
// - type 100 high from reload until count reaches compare
// - output stays high if run cleared before its falling condition
// - count downward, reload period after zero
// - status occurrence bits sticky until software clears them
module tmr_block (
  input wire logic mclk_i, // 200 MHz block clock
  input wire logic reset_i, // sync reset, active high
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic capture_pin_i, // external capture request, async
  output logic cmp_o, // compare output pin
  output logic tc_o, // terminal count pin
  output logic irq_o // status interrupt level
);

  // =====================================================
  // bus decode
  logic access;
  logic mapped;
  logic wr;
  logic rd;

  tmr_apb_decode u_dec (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .paddr_i(paddr_i),
    .access_o(access),
    .mapped_o(mapped),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );

  assign wr = access & pwrite_i & mapped;
  assign rd = access & ~pwrite_i & mapped;

  // =====================================================
  // registers
  logic [7:0] cfg0_r;
  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [15:0] period_r;
  logic [15:0] compare_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capture_r;
  logic [3:0] sticky_r;
  logic [3:0] mask_r;
  logic run_r;
  logic run_d_r;

  logic pwm_mode;
  logic stop_mode;
  logic terminal;
  logic stop_req;
  logic cmp_event;
  logic [3:0] events;
  logic cap_s1_r;
  logic cap_s2_r;
  logic cap_s3_r;
  logic cap_edge;
  tmr_pkg::pin_out_t pins;

  assign pwm_mode = cfg0_r[tmr_pkg::CFG0_MODE_BIT];
  assign stop_mode = ~pwm_mode &&
    cfg2_r[tmr_pkg::CFG2_GATE_LSB +: 2] == tmr_pkg::GATE_STOP_ON_IRQ;
  assign terminal = run_r && count_r == 16'h0000;

  // =====================================================
  // capture pin synchroniser, edge taken from second stage onward
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end else begin
      cap_s1_r <= capture_pin_i;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  assign cap_edge = cap_s2_r & ~cap_s3_r;

  // =====================================================
  // configuration writes
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg1_r <= 8'h00;
      cfg2_r <= 8'h00;
      period_r <= tmr_pkg::PERIOD_RST;
      compare_r <= tmr_pkg::COMPARE_RST;
      mask_r <= 4'h0;
    end else if (wr) begin
      case (paddr_i)
        tmr_pkg::OFS_CFG1: cfg1_r <= pwdata_i[7:0];
        tmr_pkg::OFS_CFG2: cfg2_r <= pwdata_i[7:0];
        tmr_pkg::OFS_PERIOD: period_r <= pwdata_i[15:0];
        tmr_pkg::OFS_COMPARE: compare_r <= pwdata_i[15:0];
        tmr_pkg::OFS_STATUS: mask_r <= pwdata_i[tmr_pkg::ST_MASK_LSB +: 4];
        default: mask_r <= mask_r;
      endcase
    end
  end

  // config_reg_zero with run bit cleared by hardware on stop request;
  // the hardware clear wins so a stop in the write cycle is not lost
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg0_r <= 8'h00;
    end else begin
      if (wr && paddr_i == tmr_pkg::OFS_CFG0) begin
        cfg0_r <= pwdata_i[7:0];
      end
      if (stop_req) begin
        cfg0_r[tmr_pkg::CFG0_RUN_BIT] <= 1'b0;
      end
    end
  end

  // run follows the bit; a rising run bit reloads the count first
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      run_r <= 1'b0;
      run_d_r <= 1'b0;
    end else begin
      run_r <= cfg0_r[tmr_pkg::CFG0_RUN_BIT] & ~stop_req;
      run_d_r <= run_r;
    end
  end

  // =====================================================
  // down counter with reload from period
  always_comb begin
    count_nxt = count_r;
    if (run_r && !run_d_r && count_r == 16'h0000) begin
      count_nxt = period_r;
    end else if (run_r) begin
      if (count_r == 16'h0000) begin
        count_nxt = period_r;
      end else begin
        count_nxt = count_r - 16'h0001;
      end
    end
  end

  // the count is loaded on each enable so period writes land on restart
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      count_r <= 16'h0000;
    end else if (cfg0_r[tmr_pkg::CFG0_RUN_BIT] && !run_r && !stop_req) begin
      count_r <= period_r;
    end else begin
      count_r <= count_nxt;
    end
  end

  // =====================================================
  // comparator
  tmr_compare u_cmp (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pwm_i(pwm_mode),
    .run_i(run_r),
    .reload_i(terminal),
    .type_i(cfg2_r[tmr_pkg::CFG2_CMP_LSB +: 3]),
    .count_i(count_r),
    .compare_i(compare_r),
    .cmp_o(pins.cmp),
    .event_o(cmp_event)
  );

  // terminal pin pulses at zero, or is the complement in dead band mode
  assign pins.tc = (pwm_mode && cfg0_r[tmr_pkg::CFG0_DB_BIT]) ? ~pins.cmp : terminal;

  // =====================================================
  // events and sticky status
  assign events[tmr_pkg::ST_TC] = terminal;
  assign events[tmr_pkg::ST_CMP] = cmp_event;
  assign events[tmr_pkg::ST_CAP] = cap_edge;
  assign events[tmr_pkg::ST_STOP] = stop_req;

  // any unmasked source stops the gated timer; stop itself excluded
  // to avoid a combinational loop through its own event
  assign stop_req = stop_mode && run_r &&
    |(events[2:0] & mask_r[2:0]);

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sticky_r <= 4'h0;
    end else begin
      sticky_r <= (sticky_r & ~((wr && paddr_i == tmr_pkg::OFS_STATUS) ?
        pwdata_i[3:0] : 4'h0)) | events;
    end
  end

  assign irq_o = |(sticky_r & mask_r);

  // =====================================================
  // capture register: count reads outside comparator mode copy the live count
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      capture_r <= 16'h0000;
    end else if (rd && !pwm_mode &&
      (paddr_i == tmr_pkg::OFS_COUNT || paddr_i == tmr_pkg::OFS_COUNT_LOW)) begin
      capture_r <= count_r;
    end else if (cap_edge) begin
      capture_r <= count_r;
    end
  end

  // =====================================================
  // read mux, combinational within the access cycle
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (rd) begin
      case (paddr_i)
        tmr_pkg::OFS_CFG0: prdata_o = {24'h000000, cfg0_r};
        tmr_pkg::OFS_CFG1: prdata_o = {24'h000000, cfg1_r};
        tmr_pkg::OFS_CFG2: prdata_o = {24'h000000, cfg2_r};
        tmr_pkg::OFS_PERIOD: prdata_o = {16'h0000, period_r};
        tmr_pkg::OFS_COMPARE: prdata_o = {16'h0000, compare_r};
        tmr_pkg::OFS_COUNT: prdata_o = pwm_mode ? 32'h0000_0000 : {16'h0000, count_r};
        tmr_pkg::OFS_COUNT_LOW: prdata_o = pwm_mode ? 32'h0000_0000 :
          {24'h000000, count_r[7:0]};
        tmr_pkg::OFS_CAPTURE: prdata_o = {16'h0000, capture_r};
        tmr_pkg::OFS_STATUS: prdata_o = {20'h00000, mask_r, 4'h0, sticky_r};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  assign cmp_o = pins.cmp;
  assign tc_o = pins.tc;

endmodule // tmr_block

// file: bench/tmr_block_checker.sv
`timescale 1ns/1ps
// =====================================================
// port checks; config is mirrored from apb writes
module tmr_block_checker (
  input wire logic mclk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic cmp_o, // compare pin
  input wire logic tc_o, // terminal pin
  input wire logic irq_o // interrupt level
);
  logic wr;
  logic rd;
  logic [2:0] cfg_r;
  logic [2:0] type_r;
  logic [3:0] mask_r;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & !pwrite_i;
  // mirror only; a hardware clear of run is not seen here
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg_r <= 3'h0;
      type_r <= 3'h0;
      mask_r <= 4'h0;
    end else if (wr) begin
      if (paddr_i == tmr_pkg::OFS_CFG0) cfg_r <= pwdata_i[2:0];
      if (paddr_i == tmr_pkg::OFS_CFG2) type_r <= pwdata_i[4:2];
      if (paddr_i == tmr_pkg::OFS_STATUS) mask_r <= pwdata_i[11:8];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_reset_quiet: assert property ($fell(reset_i) |-> !cmp_o && !irq_o)
    else $error("outputs not low after reset");
  a_db_complement: assert property (cfg_r[1] && cfg_r[2] |-> tc_o == !cmp_o)
    else $error("terminal pin not complement");
  a_eq_single: assert property (cfg_r[1] && type_r == 3'h0 && $rose(cmp_o) |=> !cmp_o)
    else $error("equal pulse too long");
  a_mask_blocks: assert property (mask_r == 4'h0 |-> !irq_o)
    else $error("interrupt while masked");
  a_count_hidden: assert property (cfg_r[1] && rd && paddr_i == tmr_pkg::OFS_COUNT
    |-> prdata_o == 32'h0)
    else $error("count readable in comparator mode");
  a_tc_pulse: assert property (!(cfg_r[1] && cfg_r[2]) && tc_o |=> !tc_o)
    else $error("terminal pulse too long");
  a_stop_holds: assert property (cfg_r[1] && !cfg_r[0] |=> $stable(cmp_o))
    else $error("compare pin moved while stopped");
  a_irq_sticky: assert property (irq_o && !(wr && paddr_i == tmr_pkg::OFS_STATUS)
    |=> irq_o)
    else $error("interrupt dropped without clear");
  cover property (cfg_r[1] && $fell(cmp_o));
  cover property ($rose(irq_o));
  cover property (cfg_r[2] && tc_o);
endmodule // tmr_block_checker

// file: bench/tmr_block_tb.sv
`timescale 1ns/1ps
// =====================================================
// bench: apb master, scenario tasks, verdict
module tmr_block_tb;
  logic mclk_i, reset_i, psel_i, penable_i, pwrite_i, capture_pin_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, v;
  logic pready_o, pslverr_o, cmp_o, tc_o, irq_o, err;
  int errors, checks, n, w2;
  int wid[5] = '{1, 4, 5, 6, 7};

  tmr_block tmr_block_inst (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .capture_pin_i(capture_pin_i), .cmp_o(cmp_o), .tc_o(tc_o), .irq_o(irq_o));

  // 200 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // =====================================================
  // one transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rst();
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask

  // waits at falling edges for the pin level; n counts the cycles
  task automatic wait_cmp(input logic l);
    n = 0;
    while (cmp_o !== l && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    // a level that never comes is a mismatch, not a silent short count
    if (n >= 100) errors++;
  endtask

  // =====================================================
  // stop on interrupt, self clear of run, sticky status
  task automatic t_stop();
    rst();
    apb(1'b1, tmr_pkg::OFS_PERIOD, 32'h8);
    apb(1'b1, tmr_pkg::OFS_CFG2, 32'h3);
    apb(1'b1, tmr_pkg::OFS_STATUS, 32'h100);
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h1);
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 100) errors++;
    apb(1'b0, tmr_pkg::OFS_CFG0, 32'h0);
    chk("run bit", 32'h0, {31'h0, rd[0]});
    apb(1'b0, tmr_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h109, rd & 32'hF0D);
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    v = rd;
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    chk("stopped count", v, rd);
    chk("irq held", 32'h1, {31'h0, irq_o});
    apb(1'b1, tmr_pkg::OFS_STATUS, 32'h10F);
    @(negedge mclk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h1);
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    v = rd;
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    chk("count resumed", 32'h1, {31'h0, rd !== v});
  endtask

  // count reads copy into capture; unmapped access errors
  task automatic t_cap();
    rst();
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h1);
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    v = rd;
    apb(1'b0, tmr_pkg::OFS_CAPTURE, 32'h0);
    chk("capture word", v, rd);
    apb(1'b0, tmr_pkg::OFS_COUNT_LOW, 32'h0);
    v = rd;
    apb(1'b0, tmr_pkg::OFS_CAPTURE, 32'h0);
    chk("capture low", {24'h0, v[7:0]}, {24'h0, rd[7:0]});
    apb(1'b0, 8'h3C, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    // capture pin edge needs the two-stage synchroniser plus the edge stage
    capture_pin_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    apb(1'b0, tmr_pkg::OFS_STATUS, 32'h0);
    chk("capture status", 32'h4, rd & 32'h4);
    capture_pin_i <= 1'b0;
  endtask

  // one compare type: width and period of a clean pulse, period 10, compare 4
  task automatic t_cmp(input logic [2:0] t, input int w);
    rst();
    apb(1'b1, tmr_pkg::OFS_PERIOD, 32'hA);
    apb(1'b1, tmr_pkg::OFS_COMPARE, 32'h4);
    apb(1'b1, tmr_pkg::OFS_CFG2, {27'h0, t, 2'h0});
    apb(1'b1, tmr_pkg::OFS_STATUS, 32'h200);
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h3);
    wait_cmp(1'b1);
    wait_cmp(1'b0);
    wait_cmp(1'b1);
    wait_cmp(1'b0);
    w2 = n;
    chk("pulse width", w, w2);
    wait_cmp(1'b1);
    chk("pwm period", 32'hB, w2 + n);
    chk("compare irq", 32'h1, {31'h0, irq_o});
    apb(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
    chk("hidden count", 32'h0, rd);
  endtask

  // dead band complement, hold on stop, masked interrupt
  task automatic t_db();
    rst();
    apb(1'b1, tmr_pkg::OFS_PERIOD, 32'hA);
    apb(1'b1, tmr_pkg::OFS_COMPARE, 32'h4);
    apb(1'b1, tmr_pkg::OFS_CFG2, {27'h0, tmr_pkg::CMP_GE, 2'h0});
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h7);
    wait_cmp(1'b1);
    chk("tc complement", {31'h0, ~cmp_o}, {31'h0, tc_o});
    apb(1'b1, tmr_pkg::OFS_CFG0, 32'h6);
    repeat (12) @(negedge mclk_i);
    chk("held compare", 32'h1, {31'h0, cmp_o});
    chk("masked irq", 32'h0, {31'h0, irq_o});
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, capture_pin_i} = 4'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    reset_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_stop();
    t_cap();
    for (int i = 0; i < 5; i++) t_cmp(i[2:0], wid[i]);
    t_db();
    finish_test();
  end

  // the whole run needs several hundred cycles; this is far beyond it
  initial begin
    #200000;
    errors++;
    finish_test();
  end
endmodule // tmr_block_tb

bind tmr_block tmr_block_checker tmr_block_checker_inst (.mclk_i(mclk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .cmp_o(cmp_o),
  .tc_o(tc_o), .irq_o(irq_o));
